/* hdl/rbs_consts.svh */
// Constants for the reset and boot selection block
`ifndef RBS_CONSTS_SVH
`define RBS_CONSTS_SVH
`define RBS_PC_START        16'h0000
`define RBS_SEQ_CYCLES      4'h8
`define RBS_SRC_POWER_ON    3'h0
`define RBS_SRC_HW_PIN      3'h1
`define RBS_SRC_WATCHDOG    3'h2
`define RBS_SRC_WAKEUP      3'h3
`define RBS_SRC_BROWNOUT    3'h4
`define RBS_SRC_NONE        3'h7
`define RBS_BOOT_RESET_VAL  3'h0
`define RBS_PIN_SYNC_IDLE   2'h2
`endif

/* hdl/rbs_pkg.sv */
// Types shared by the reset and boot selection block
package rbs_pkg;
    typedef enum logic [2:0] {
        RBS_BOOT_USER       = 3'b000,
        RBS_BOOT_LOADER     = 3'b001,
        RBS_BOOT_DEBUG      = 3'b010,
        RBS_BOOT_USER_JTAG  = 3'b011,
        RBS_BOOT_INVALID    = 3'b111
    } rbs_boot_t;
    typedef enum logic [1:0] {
        RBS_LDR_UART = 2'b00,
        RBS_LDR_LIN  = 2'b01,
        RBS_LDR_ALT  = 2'b10
    } rbs_loader_t;
    typedef enum logic [1:0] {
        RBS_ST_RUN    = 2'b00,
        RBS_ST_RESET  = 2'b01,
        RBS_ST_LATCH  = 2'b10
    } rbs_state_t;
endpackage

/* hdl/rbs_sync.sv */
// Two-stage synchroniser for a bus of asynchronous pin levels
`timescale 1ns/100ps
`default_nettype none
module rbs_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    input  wire logic             clk_en,
    // Levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    // First stage is read only by the second
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            // Idle level, so no false request follows reset
            meta_r   <= RST_VAL;
            sync_out <= RST_VAL;
        end else if (clk_en) begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule
`default_nettype wire

/* hdl/rbs_top.sv */
// Reset sequencer and boot option latch
`timescale 1ns/100ps
`default_nettype none
`include "rbs_consts.svh"
module rbs_top (
    // Clock, reset, enable
    input  wire logic               ref_clk,
    input  wire logic               resetn,
    input  wire logic               clk_en,
    // Reset source requests (pins asynchronous, rest from logic)
    input  wire logic               por_req,
    input  wire logic               hw_reset_pin_n,
    input  wire logic               watchdog_timer_req,
    input  wire logic               wakeup_req,
    input  wire logic               brownout_req,
    input  wire logic               power_down_active,
    // Strap pins
    input  wire logic               boot_mode_select_pin,
    input  wire logic               jtag_tms_pin,
    input  wire logic               boot_option_pin,
    input  wire logic               test_mode_pin,
    input  wire logic               default_pins_sel,
    // Flash conditions
    input  wire logic               password_valid,
    input  wire logic               first_byte_zero,
    input  wire logic               alternate_loader_password,
    input  wire logic               lin_variant,
    // Reset outputs
    output logic                    core_reset_n,
    output logic                    ram_invalid,
    output logic                    voltage_regulator_on,
    // Boot result
    output rbs_pkg::rbs_boot_t      boot_mode,
    output rbs_pkg::rbs_loader_t    loader_kind,
    output logic [15:0]             pc_start,
    output logic [2:0]              reset_source
);
    import rbs_pkg::*;

    logic [1:0] pin_sync;
    logic [3:0] strap_sync;
    logic       hw_req;
    logic [2:0] src_nxt;
    logic       any_req;
    logic [3:0] seq_cnt_r;
    rbs_state_t state_r;
    logic [2:0] pend_src_r;
    logic       rebind_r;

    // Pins cross into the clock domain before any decoding
    rbs_sync #(.WIDTH(2), .RST_VAL(`RBS_PIN_SYNC_IDLE)) u_pin_sync (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .clk_en   (clk_en),
        .async_in ({hw_reset_pin_n, test_mode_pin}),
        .sync_out (pin_sync)
    );
    rbs_sync #(.WIDTH(4)) u_strap_sync (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .clk_en   (clk_en),
        .async_in ({boot_mode_select_pin, jtag_tms_pin, boot_option_pin,
                    default_pins_sel}),
        .sync_out (strap_sync)
    );

    // Strap decode; option pin ignored when TMS is low
    function automatic rbs_boot_t decode_straps(input logic [2:0] s);
        case (s[2:1])
            2'b10:   decode_straps = RBS_BOOT_USER;
            2'b00:   decode_straps = RBS_BOOT_LOADER;
            2'b01:   decode_straps = s[0] ? RBS_BOOT_INVALID : RBS_BOOT_DEBUG;
            2'b11:   decode_straps = s[0] ? RBS_BOOT_INVALID : RBS_BOOT_USER_JTAG;
            default: decode_straps = RBS_BOOT_INVALID;
        endcase
    endfunction

    // Pin reset counts in run and in power-down alike
    assign hw_req = ~pin_sync[1];

    // Source priority: power-on, brownout, pin, watchdog, wake-up
    always_comb begin
        src_nxt = `RBS_SRC_NONE;
        if (por_req)
            src_nxt = `RBS_SRC_POWER_ON;
        else if (brownout_req)
            src_nxt = `RBS_SRC_BROWNOUT;
        else if (hw_req)
            src_nxt = `RBS_SRC_HW_PIN;
        else if (watchdog_timer_req)
            src_nxt = `RBS_SRC_WATCHDOG;
        else if (wakeup_req && power_down_active)
            src_nxt = `RBS_SRC_WAKEUP;
    end
    assign any_req = (src_nxt != `RBS_SRC_NONE);

    // Sequencer: a new request restarts the count so the longest source wins
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_r   <= RBS_ST_RESET;
            seq_cnt_r <= 4'h0;
        end else if (clk_en) begin
            case (state_r)
                RBS_ST_RUN: begin
                    if (any_req) begin
                        state_r   <= RBS_ST_RESET;
                        seq_cnt_r <= 4'h0;
                    end
                end
                RBS_ST_RESET: begin
                    if (any_req)
                        seq_cnt_r <= 4'h0;
                    else if (seq_cnt_r == `RBS_SEQ_CYCLES - 4'h1)
                        state_r <= RBS_ST_LATCH;
                    else
                        seq_cnt_r <= seq_cnt_r + 4'h1;
                end
                RBS_ST_LATCH: begin
                    state_r <= any_req ? RBS_ST_RESET : RBS_ST_RUN;
                    seq_cnt_r <= 4'h0;
                end
                default: state_r <= RBS_ST_RESET;
            endcase
        end
    end

    // Remember source; an asynchronous reset counts as power-on
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pend_src_r <= `RBS_SRC_POWER_ON;
            rebind_r   <= 1'b1;
        end else if (clk_en) begin
            if (any_req && (state_r != RBS_ST_RESET || src_nxt <= pend_src_r ||
                            !rebind_r)) begin
                pend_src_r <= src_nxt;
                if (src_nxt == `RBS_SRC_POWER_ON || src_nxt == `RBS_SRC_HW_PIN ||
                    src_nxt == `RBS_SRC_BROWNOUT)
                    rebind_r <= 1'b1;
                else if (state_r != RBS_ST_RESET)
                    rebind_r <= 1'b0;
            end
        end
    end

    // Core held in reset during the sequence and latch cycle
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            core_reset_n <= 1'b0;
            reset_source <= `RBS_SRC_NONE;
        end else if (clk_en) begin
            core_reset_n <= (state_r == RBS_ST_LATCH || state_r == RBS_ST_RUN) && !any_req;
            if (state_r == RBS_ST_LATCH)
                reset_source <= pend_src_r;
        end
    end

    // RAM trust and regulator follow the source
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ram_invalid          <= 1'b1;
            voltage_regulator_on <= 1'b1;
        end else if (clk_en) begin
            if (any_req) begin
                if (src_nxt == `RBS_SRC_POWER_ON || src_nxt == `RBS_SRC_BROWNOUT)
                    ram_invalid <= 1'b1;
                if (src_nxt == `RBS_SRC_WAKEUP || src_nxt == `RBS_SRC_POWER_ON ||
                    src_nxt == `RBS_SRC_BROWNOUT)
                    voltage_regulator_on <= 1'b1;
                else if (power_down_active && src_nxt == `RBS_SRC_NONE)
                    voltage_regulator_on <= voltage_regulator_on;
            end else if (power_down_active) begin
                voltage_regulator_on <= 1'b0;
            end else if (state_r == RBS_ST_RUN) begin
                ram_invalid <= 1'b0; // Software now owns RAM contents
            end
        end
    end

    // Boot latch: only at sequence end after a binding source
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            boot_mode   <= rbs_boot_t'(`RBS_BOOT_RESET_VAL);
            loader_kind <= RBS_LDR_UART;
            pc_start    <= `RBS_PC_START;
        end else if (clk_en) begin
            if (state_r == RBS_ST_LATCH && rebind_r && !any_req) begin
                pc_start <= `RBS_PC_START;
                // Test-mode high or alternate pin set voids the strap choice
                if (!strap_sync[0] || pin_sync[0])
                    boot_mode <= RBS_BOOT_USER;
                else if (decode_straps(strap_sync[3:1]) == RBS_BOOT_USER &&
                         !password_valid && first_byte_zero)
                    boot_mode <= RBS_BOOT_LOADER;
                else
                    boot_mode <= decode_straps(strap_sync[3:1]);
                if (lin_variant)
                    loader_kind <= RBS_LDR_LIN;
                else if (alternate_loader_password)
                    loader_kind <= RBS_LDR_ALT;
                else
                    loader_kind <= RBS_LDR_UART;
            end
        end
    end

    // Boot choice only moves when a binding sequence ends
    property p_boot_stable;
        @(posedge ref_clk) disable iff (!resetn)
        (clk_en && !(state_r == RBS_ST_LATCH && rebind_r)) |=> $stable(boot_mode);
    endproperty
    a_boot_stable: assert property (p_boot_stable) else $error("boot moved");

    property p_lin_wins;
        @(posedge ref_clk) disable iff (!resetn)
        (clk_en && state_r == RBS_ST_LATCH && rebind_r && !any_req && lin_variant)
        |=> loader_kind == RBS_LDR_LIN;
    endproperty
    a_lin_wins: assert property (p_lin_wins) else $error("LIN loader lost");

    property p_hold_reset;
        @(posedge ref_clk) disable iff (!resetn)
        (clk_en && any_req) |=> !core_reset_n;
    endproperty
    a_hold_reset: assert property (p_hold_reset) else $error("core not reset");

    property p_pin_reset;
        @(posedge ref_clk) disable iff (!resetn)
        (clk_en && hw_req && !por_req && !brownout_req) |=> pend_src_r == `RBS_SRC_HW_PIN;
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("pin reset lost");

    property p_wdt_reset;
        @(posedge ref_clk) disable iff (!resetn)
        (clk_en && src_nxt == `RBS_SRC_WATCHDOG) |=> state_r == RBS_ST_RESET;
    endproperty
    a_wdt_reset: assert property (p_wdt_reset) else $error("watchdog ignored");

    property p_ram_bad;
        @(posedge ref_clk) disable iff (!resetn)
        (clk_en && (src_nxt == `RBS_SRC_POWER_ON || src_nxt == `RBS_SRC_BROWNOUT))
        |=> ram_invalid;
    endproperty
    a_ram_bad: assert property (p_ram_bad) else $error("RAM still trusted");

    property p_vreg_on;
        @(posedge ref_clk) disable iff (!resetn)
        (clk_en && src_nxt == `RBS_SRC_WAKEUP) |=> voltage_regulator_on;
    endproperty
    a_vreg_on: assert property (p_vreg_on) else $error("regulator off");

    property p_pc_zero;
        @(posedge ref_clk) disable iff (!resetn)
        1'b1 |-> pc_start == `RBS_PC_START;
    endproperty
    a_pc_zero: assert property (p_pc_zero) else $error("bad start address");
endmodule
`default_nettype wire

/* bench/rbs_board.sv */
// Board model: reset button, strap resistors and pin-set select
`timescale 1ns/100ps
`default_nettype none
module rbs_board (
    // Clock and bench commands
    input  wire logic       ref_clk,
    input  wire logic       press,
    input  wire logic [3:0] hold_len,
    input  wire logic [2:0] strap_set,
    input  wire logic       dflt_set,
    // Board-side pins
    output logic            hw_reset_pin_n,
    output logic            boot_mode_select_pin,
    output logic            jtag_tms_pin,
    output logic            boot_option_pin,
    output logic            test_mode_pin,
    output logic            default_pins_sel
);
    // Pins settle at the first edge, well inside the bench reset
    logic [3:0] cnt_r = 4'h0;
    // Test-mode pin sits on a pull-down whatever the boot option
    assign test_mode_pin = 1'b0;
    // Button held low for hold_len cycles, so both prompt and slow presses occur
    always @(posedge ref_clk) begin
        if (press) begin
            cnt_r <= hold_len;
        end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
        end
        hw_reset_pin_n <= !(press || cnt_r > 4'h1);
        // Straps follow strap_set on every edge, whatever the pin set
        {boot_mode_select_pin, jtag_tms_pin, boot_option_pin} <= strap_set;
        default_pins_sel <= dflt_set;
    end
endmodule
`default_nettype wire

/* bench/reset_and_boot_select_tb_top.sv */
// Self-checking bench for the reset sequencer and boot latch
`timescale 1ns/100ps
`default_nettype none
module reset_and_boot_select_tb_top;
    import rbs_pkg::*;
    logic ref_clk, resetn, clk_en, por, wd, wake, brown, pd, pv, fz, alt, lin;
    logic press, dflt, rst_pin_n, msel, tms, opt, tmode, dsel;
    logic [3:0] hold;
    logic [2:0] straps, src;
    logic core_n, ram_inv, reg_on;
    logic [15:0] pc;
    rbs_boot_t boot, keep;
    rbs_loader_t ldr;
    int n_errors = 0;
    int cmp_count = 0;
    int seed = 32'h2492;

    rbs_board rbs_board_i (.ref_clk(ref_clk), .press(press), .hold_len(hold),
        .strap_set(straps), .dflt_set(dflt), .hw_reset_pin_n(rst_pin_n),
        .boot_mode_select_pin(msel), .jtag_tms_pin(tms), .boot_option_pin(opt),
        .test_mode_pin(tmode), .default_pins_sel(dsel));
    rbs_top rbs_top_i (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en),
        .por_req(por), .hw_reset_pin_n(rst_pin_n), .watchdog_timer_req(wd),
        .wakeup_req(wake), .brownout_req(brown), .power_down_active(pd),
        .boot_mode_select_pin(msel), .jtag_tms_pin(tms), .boot_option_pin(opt),
        .test_mode_pin(tmode), .default_pins_sel(dsel), .password_valid(pv),
        .first_byte_zero(fz), .alternate_loader_password(alt), .lin_variant(lin),
        .core_reset_n(core_n), .ram_invalid(ram_inv), .voltage_regulator_on(reg_on),
        .boot_mode(boot), .loader_kind(ldr), .pc_start(pc), .reset_source(src));

    // Free-running 40 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude;
        $display("Mismatches %0d, comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Bounded wait for the core reset to reach a level
    task automatic wait_core(input logic v, input int lim);
        for (int i = 0; i < lim && core_n !== v; i++) begin
            @(posedge ref_clk);
            #1;
        end
        if (core_n !== v) begin
            check("core reset wait", 16'(core_n), 16'(v));
            conclude();
        end
    endtask

    // Strap table with forced loader and pin-set override
    function automatic rbs_boot_t exp_boot(input logic [2:0] s, input logic d);
        if (!d) return RBS_BOOT_USER;
        case (s[2:1])
            2'b10: return (!pv && fz) ? RBS_BOOT_LOADER : RBS_BOOT_USER;
            2'b00: return RBS_BOOT_LOADER;
            2'b01: return s[0] ? RBS_BOOT_INVALID : RBS_BOOT_DEBUG;
            default: return s[0] ? RBS_BOOT_INVALID : RBS_BOOT_USER_JTAG;
        endcase
    endfunction

    // One reset of kind k: 0 power-on, 1 pin, 2 watchdog, 3 wake-up, 4 brownout
    task automatic fire(input int k);
        logic reg_before;
        reg_before = reg_on;
        @(posedge ref_clk);
        case (k)
            0: por <= 1'b1;
            1: press <= 1'b1;
            2: wd <= 1'b1;
            3: wake <= 1'b1;
            default: brown <= 1'b1;
        endcase
        @(posedge ref_clk);
        {por, press, wd, wake, brown} <= 5'h00;
        // Power-down drops at once after a wake-up, else stays up until the core is held, so a pin reset lands in it
        if (k == 3) pd <= 1'b0;
        wait_core(1'b0, 12);
        @(posedge ref_clk);
        pd <= 1'b0;
        #1;
        check("ram_invalid", 16'(ram_inv), 16'(k == 0 || k == 4));
        if (k == 2) check("regulator", 16'(reg_on), 16'(reg_before));
        wait_core(1'b1, 60);
        repeat (2) @(posedge ref_clk);
        #1;
        check("reset_source", 16'(src), 16'(k));
        check("pc_start", pc, 16'h0000);
    endtask

    initial begin
        {clk_en, pv, dflt} = 3'b111;
        {resetn, por, wd, wake, brown, pd, fz, alt, lin, press} = 10'h000;
        hold = 4'h3;
        straps = 3'b100;
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        wait_core(1'b1, 60);
        repeat (2) @(posedge ref_clk);
        #1;
        check("boot after release", 16'(boot), 16'(RBS_BOOT_USER));
        check("ram cleared", 16'(ram_inv), 16'h0000);
        // Pin resets over every strap code, then a watchdog that must not relatch
        for (int n = 0; n < 14; n++) begin
            @(posedge ref_clk);
            straps <= (n < 8) ? 3'(n) : 3'($random(seed));
            hold <= 4'(2 + ($random(seed) & 7));
            {alt, lin} <= 2'($random(seed));
            fire(1);
            check("boot", 16'(boot), 16'(exp_boot(straps, 1'b1)));
            check("loader", 16'(ldr),
                16'(lin ? RBS_LDR_LIN : alt ? RBS_LDR_ALT : RBS_LDR_UART));
            keep = boot;
            @(posedge ref_clk);
            straps <= ~straps;
            fire(2);
            check("boot held", 16'(boot), 16'(keep));
        end
        // Forced loader on an empty, unprotected flash
        @(posedge ref_clk);
        {pv, fz} <= 2'b01;
        straps <= 3'b100;
        fire(1);
        check("forced loader", 16'(boot), 16'(RBS_BOOT_LOADER));
        @(posedge ref_clk);
        pv <= 1'b1;
        // Non-default pin set ignores the straps
        dflt <= 1'b0;
        straps <= 3'b010;
        fire(1);
        check("pin set", 16'(boot), 16'(RBS_BOOT_USER));
        @(posedge ref_clk);
        dflt <= 1'b1;
        fire(4);
        check("brownout relatch", 16'(boot), 16'(RBS_BOOT_DEBUG));
        // Power-down: regulator off, wake-up turns it back on
        @(posedge ref_clk);
        pd <= 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        check("regulator off", 16'(reg_on), 16'h0000);
        fire(3);
        check("regulator on", 16'(reg_on), 16'h0001);
        @(posedge ref_clk);
        pd <= 1'b1;
        fire(1);
        fire(0);
        conclude();
    end
endmodule
`default_nettype wire
